// >>> src/pair_mode_pkg.sv
// Package: constants, register map and carriers for the pair mode and decoder select block
package pair_mode_pkg;

	// Geometry
	localparam int NUM_PAIRS      = 8;
	localparam int SDI_PAIRS      = 8;
	localparam int AES_PAIRS_BASE = 4;
	localparam int AES_PAIRS_EXT  = 6;
	localparam int SRC_W          = 4;
	localparam int SAMPLE_W       = 24;

	// Decoder channel limits per compressed format
	localparam logic [3:0] MAX_CH_CONSUMER = 4'h6;
	localparam logic [3:0] MAX_CH_PRO      = 4'h8;

	// Register byte offsets
	localparam logic [11:0] ADDR_PAIR_MODE  = 12'h000;
	localparam logic [11:0] ADDR_PAIR_SRC   = 12'h004;
	localparam logic [11:0] ADDR_DEC_SEL    = 12'h008;
	localparam logic [11:0] ADDR_META_DEST  = 12'h00C;
	localparam logic [11:0] ADDR_DEC_STATUS = 12'h010;

	// Reset values
	localparam logic [31:0] RST_PAIR_MODE = 32'h0000_0000;
	localparam logic [31:0] RST_PAIR_SRC  = 32'h0000_0000;
	localparam logic [3:0]  RST_DEC_SEL   = 4'h0;
	localparam logic [1:0]  RST_META_DEST = 2'h0;

	// Field positions in the decoder status word
	localparam int FMT_LSB   = 0;
	localparam int DIAL_LSB  = 8;
	localparam int CHCNT_LSB = 16;

	typedef enum logic [1:0] {
		MODE_AUDIO,
		MODE_DATA,
		MODE_AUTO,
		MODE_RSVD
	} pair_mode_e;

	typedef enum logic [2:0] {
		FMT_NONE,
		FMT_PCM,
		FMT_CONSUMER,
		FMT_PRO,
		FMT_UNKNOWN
	} in_format_e;

	// One AES-style sample pair with its audio/data flag
	typedef struct packed {
		logic                valid;
		logic                is_data;
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
	} pair_s;

	// Metadata byte heading for a serial port
	typedef struct packed {
		logic       valid;
		logic [1:0] port;
		logic [7:0] data;
	} meta_s;

endpackage : pair_mode_pkg

// >>> src/dec_src_mux.sv
// Decoder source selector: one embedded or AES pair goes to the decoder
`timescale 1ns/10ps
module dec_src_mux #(
	parameter bit EXTENDED = 1'b0
) (
	// Clock and control
	input  wire logic                                               i_mclk,
	input  wire logic                                               i_rst_n,
	input  wire logic                                               i_ce,
	input  wire logic [pair_mode_pkg::SRC_W-1:0]                    i_sel,
	// Candidate sources
	input  wire pair_mode_pkg::pair_s [pair_mode_pkg::SDI_PAIRS-1:0]     i_sdi,
	input  wire pair_mode_pkg::pair_s [pair_mode_pkg::AES_PAIRS_EXT-1:0] i_aes,
	// Selected stream
	output pair_mode_pkg::pair_s                                    o_dec
);

	localparam int NUM_SRC = pair_mode_pkg::SDI_PAIRS +
		(EXTENDED ? pair_mode_pkg::AES_PAIRS_EXT : pair_mode_pkg::AES_PAIRS_BASE);

	// Out-of-range selections give a silent stream rather than a stale one
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_dec <= '0;
		end else if (i_ce) begin
			if (int'(i_sel) >= NUM_SRC) begin
				o_dec <= '0;
			end else if (int'(i_sel) < pair_mode_pkg::SDI_PAIRS) begin
				o_dec <= i_sdi[i_sel[2:0]];
			end else begin
				o_dec <= i_aes[3'(i_sel - 4'(pair_mode_pkg::SDI_PAIRS))];
			end
		end
	end

	property p_range;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && int'(i_sel) >= NUM_SRC) |=> (o_dec == '0);
	endproperty
	a_range: assert property (p_range) else $error("out-of-range source not silenced");

	property p_sdi_pick;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_sel < 4'h8) |=> (o_dec == $past(i_sdi[i_sel[2:0]]));
	endproperty
	a_sdi_pick: assert property (p_sdi_pick) else $error("embedded pair not routed to decoder");

	property p_aes_pick;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_sel == 4'h8) |=> (o_dec == $past(i_aes[0]));
	endproperty
	a_aes_pick: assert property (p_aes_pick) else $error("first AES pair not routed");

endmodule : dec_src_mux

// >>> src/pair_path.sv
// One mixer input pair: source pick and audio/data handling
`timescale 1ns/10ps
module pair_path (
	// Clock and control
	input  wire logic                                            i_mclk,
	input  wire logic                                            i_rst_n,
	input  wire logic                                            i_ce,
	input  wire pair_mode_pkg::pair_mode_e                       i_mode,
	input  wire logic                                            i_from_dec,
	input  wire logic [2:0]                                      i_sel,
	// Sources
	input  wire pair_mode_pkg::pair_s [pair_mode_pkg::SDI_PAIRS-1:0] i_sdi,
	input  wire pair_mode_pkg::pair_s [3:0]                      i_dec,
	// Mixer returns for this pair
	input  wire pair_mode_pkg::pair_s                            i_mix,
	// Outputs
	output pair_mode_pkg::pair_s                                 o_to_mix,
	output pair_mode_pkg::pair_s                                 o_out,
	output logic                                                 o_bypass
);

	pair_mode_pkg::pair_s src;
	logic                 data_path;

	always_comb begin
		src = i_from_dec ? i_dec[i_sel[1:0]] : i_sdi[i_sel];
	end

	// Reserved mode code behaves as data: safest for unknown payloads
	always_comb begin
		case (i_mode)
			pair_mode_pkg::MODE_AUDIO: data_path = 1'b0;
			pair_mode_pkg::MODE_DATA:  data_path = 1'b1;
			pair_mode_pkg::MODE_AUTO:  data_path = src.is_data;
			default:                   data_path = 1'b1;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_to_mix <= '0;
			o_bypass <= 1'b0;
		end else if (i_ce) begin
			o_to_mix <= data_path ? '0 : src;
			o_bypass <= data_path;
		end
	end

	// Bypass is the registered source itself, so payload bits are never touched
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_out <= '0;
		end else if (i_ce) begin
			o_out <= data_path ? src : i_mix;
		end
	end

	property p_data_exact;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_mode == pair_mode_pkg::MODE_DATA) |=> (o_out == $past(src) && o_bypass);
	endproperty
	a_data_exact: assert property (p_data_exact) else $error("data pair not bit exact");

	property p_audio_mix;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_mode == pair_mode_pkg::MODE_AUDIO) |=> (o_to_mix == $past(src) && !o_bypass);
	endproperty
	a_audio_mix: assert property (p_audio_mix) else $error("audio pair not sent to mixer");

	property p_auto_flag;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_mode == pair_mode_pkg::MODE_AUTO) |=> (o_bypass == $past(src.is_data));
	endproperty
	a_auto_flag: assert property (p_auto_flag) else $error("auto mode ignored flag");

endmodule : pair_path

// >>> src/pair_mode_top.sv
// Top: mixer pair modes, decoder source select, format and metadata status over APB
`timescale 1ns/10ps
module pair_mode_top #(
	parameter bit EXTENDED = 1'b0
) (
	// Clock, reset, enable
	input  wire logic                                                i_mclk,
	input  wire logic                                                i_rst_n,
	input  wire logic                                                i_ce,
	// APB slave
	input  wire logic                                                i_psel,
	input  wire logic                                                i_penable,
	input  wire logic                                                i_pwrite,
	input  wire logic [11:0]                                         i_paddr,
	input  wire logic [31:0]                                         i_pwdata,
	output logic [31:0]                                              o_prdata,
	output logic                                                     o_pready,
	output logic                                                     o_pslverr,
	// Audio sources
	input  wire pair_mode_pkg::pair_s [pair_mode_pkg::SDI_PAIRS-1:0]     i_sdi,
	input  wire pair_mode_pkg::pair_s [pair_mode_pkg::AES_PAIRS_EXT-1:0] i_aes,
	// Decoder side
	input  wire pair_mode_pkg::pair_s [3:0]                          i_dec_out,
	input  wire logic [2:0]                                          i_dec_format,
	input  wire logic [3:0]                                          i_dec_chcnt,
	input  wire logic                                                i_meta_valid,
	input  wire logic [7:0]                                          i_meta_byte,
	input  wire logic                                                i_dial_valid,
	input  wire logic [4:0]                                          i_dial_level,
	output pair_mode_pkg::pair_s                                     o_dec_in,
	// Mixer side
	input  wire pair_mode_pkg::pair_s [pair_mode_pkg::NUM_PAIRS-1:0] i_mix,
	output pair_mode_pkg::pair_s [pair_mode_pkg::NUM_PAIRS-1:0]      o_to_mix,
	output pair_mode_pkg::pair_s [pair_mode_pkg::NUM_PAIRS-1:0]      o_out,
	output logic [pair_mode_pkg::NUM_PAIRS-1:0]                      o_bypass,
	// Metadata toward serial ports
	output pair_mode_pkg::meta_s                                     o_meta
);

	localparam int NP = pair_mode_pkg::NUM_PAIRS;

	logic [31:0]                 pair_mode;
	logic [31:0]                 pair_src;
	logic [3:0]                  dec_sel;
	logic [1:0]                  meta_dest;
	pair_mode_pkg::in_format_e   fmt;
	logic [4:0]                  dial;
	logic [3:0]                  chcnt;
	logic                        wr_en;
	logic                        rd_en;
	logic                        addr_ok;
	logic [31:0]                 next_prdata;
	logic [3:0]                  next_chcnt;
	pair_mode_pkg::in_format_e   next_fmt;

	// Writes take effect only in the access cycle; slave answers with zero wait states
	assign wr_en = i_psel && i_penable && i_pwrite;
	assign rd_en = i_psel && i_penable && !i_pwrite;

	always_comb begin
		case (i_paddr)
			pair_mode_pkg::ADDR_PAIR_MODE,
			pair_mode_pkg::ADDR_PAIR_SRC,
			pair_mode_pkg::ADDR_DEC_SEL,
			pair_mode_pkg::ADDR_META_DEST,
			pair_mode_pkg::ADDR_DEC_STATUS: addr_ok = 1'b1;
			default:                        addr_ok = 1'b0;
		endcase
	end

	// Control registers; a write to the status word is refused
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pair_mode <= pair_mode_pkg::RST_PAIR_MODE;
			pair_src  <= pair_mode_pkg::RST_PAIR_SRC;
			dec_sel   <= pair_mode_pkg::RST_DEC_SEL;
			meta_dest <= pair_mode_pkg::RST_META_DEST;
		end else if (i_ce && wr_en) begin
			case (i_paddr)
				pair_mode_pkg::ADDR_PAIR_MODE: pair_mode <= i_pwdata;
				pair_mode_pkg::ADDR_PAIR_SRC:  pair_src  <= i_pwdata;
				pair_mode_pkg::ADDR_DEC_SEL:   dec_sel   <= i_pwdata[3:0];
				pair_mode_pkg::ADDR_META_DEST: meta_dest <= i_pwdata[1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		case (i_paddr)
			pair_mode_pkg::ADDR_PAIR_MODE:  next_prdata = pair_mode;
			pair_mode_pkg::ADDR_PAIR_SRC:   next_prdata = pair_src;
			pair_mode_pkg::ADDR_DEC_SEL:    next_prdata = {28'h0000000, dec_sel};
			pair_mode_pkg::ADDR_META_DEST:  next_prdata = {30'h00000000, meta_dest};
			pair_mode_pkg::ADDR_DEC_STATUS: begin
				next_prdata[pair_mode_pkg::FMT_LSB +: 3]   = fmt;
				next_prdata[pair_mode_pkg::DIAL_LSB +: 5]  = dial;
				next_prdata[pair_mode_pkg::CHCNT_LSB +: 4] = chcnt;
			end
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_prdata  <= 32'h0000_0000;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else if (i_ce) begin
			o_pready  <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && (!addr_ok ||
				(i_pwrite && i_paddr == pair_mode_pkg::ADDR_DEC_STATUS));
			o_prdata  <= (i_psel && !i_penable && !i_pwrite) ? next_prdata : o_prdata;
		end
	end

	// Unknown codes from the decoder report as unknown, not as a stale value
	always_comb begin
		case (i_dec_format)
			3'h0:    next_fmt = pair_mode_pkg::FMT_NONE;
			3'h1:    next_fmt = pair_mode_pkg::FMT_PCM;
			3'h2:    next_fmt = pair_mode_pkg::FMT_CONSUMER;
			3'h3:    next_fmt = pair_mode_pkg::FMT_PRO;
			default: next_fmt = pair_mode_pkg::FMT_UNKNOWN;
		endcase
	end

	// One clamp serves both compressed formats
	function automatic logic [3:0] clamp_ch(input logic [3:0] n, input logic [3:0] ceiling);
		return (n > ceiling) ? ceiling : n;
	endfunction : clamp_ch

	// Channel count is clamped to the ceiling of a compressed format and reads zero for any other format
	always_comb begin
		case (next_fmt)
			pair_mode_pkg::FMT_CONSUMER: next_chcnt = clamp_ch(i_dec_chcnt, pair_mode_pkg::MAX_CH_CONSUMER);
			pair_mode_pkg::FMT_PRO:      next_chcnt = clamp_ch(i_dec_chcnt, pair_mode_pkg::MAX_CH_PRO);
			default:                     next_chcnt = 4'h0;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			fmt   <= pair_mode_pkg::FMT_NONE;
			chcnt <= 4'h0;
		end else if (i_ce) begin
			fmt   <= next_fmt;
			chcnt <= next_chcnt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			dial <= 5'h00;
		end else if (i_ce && i_dial_valid) begin
			dial <= i_dial_level;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_meta <= '0;
		end else if (i_ce) begin
			o_meta.valid <= i_meta_valid;
			o_meta.port  <= meta_dest;
			o_meta.data  <= i_meta_byte;
		end
	end

	dec_src_mux #(
		.EXTENDED (EXTENDED)
	) u_dec_src_mux (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_sel   (dec_sel),
		.i_sdi   (i_sdi),
		.i_aes   (i_aes),
		.o_dec   (o_dec_in)
	);

	// Pair p: mode bits [2p+1:2p]; source bits [4p+3:4p], top bit picks decoder
	for (genvar p = 0; p < NP; p++) begin : g_pair
		pair_path u_pair_path (
			.i_mclk     (i_mclk),
			.i_rst_n    (i_rst_n),
			.i_ce       (i_ce),
			.i_mode     (pair_mode_pkg::pair_mode_e'(pair_mode[2*p +: 2])),
			.i_from_dec (pair_src[4*p+3]),
			.i_sel      (pair_src[4*p +: 3]),
			.i_sdi      (i_sdi),
			.i_dec      (i_dec_out),
			.i_mix      (i_mix[p]),
			.o_to_mix   (o_to_mix[p]),
			.o_out      (o_out[p]),
			.o_bypass   (o_bypass[p])
		);
	end

	property p_chcnt_consumer;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(fmt == pair_mode_pkg::FMT_CONSUMER) |-> (chcnt <= 4'h6);
	endproperty
	a_chcnt_consumer: assert property (p_chcnt_consumer) else $error("consumer channels over six");

	property p_chcnt_pro;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(fmt == pair_mode_pkg::FMT_PRO) |-> (chcnt <= 4'h8);
	endproperty
	a_chcnt_pro: assert property (p_chcnt_pro) else $error("professional channels over eight");

	property p_fmt_track;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_dec_format == 3'h1) |=> (fmt == pair_mode_pkg::FMT_PCM);
	endproperty
	a_fmt_track: assert property (p_fmt_track) else $error("format status not tracking");

	property p_meta_port;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_meta_valid) |=> (o_meta.valid && o_meta.port == $past(meta_dest));
	endproperty
	a_meta_port: assert property (p_meta_port) else $error("metadata sent to wrong port");

	property p_dial_hold;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_dial_valid) |=> (dial == $past(i_dial_level));
	endproperty
	a_dial_hold: assert property (p_dial_hold) else $error("dialogue level not captured");

	property p_dial_keep;
		@(posedge i_mclk) disable iff (!i_rst_n)
		!(i_ce && i_dial_valid) |=> $stable(dial);
	endproperty
	a_dial_keep: assert property (p_dial_keep) else $error("dialogue level moved without strobe");

	property p_mode_write;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && wr_en && i_paddr == pair_mode_pkg::ADDR_PAIR_MODE) |=> (pair_mode == $past(i_pwdata));
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("pair mode write lost");

	property p_src_write;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && wr_en && i_paddr == pair_mode_pkg::ADDR_PAIR_SRC) |=> (pair_src == $past(i_pwdata));
	endproperty
	a_src_write: assert property (p_src_write) else $error("pair source write lost");

	property p_dec_sel_write;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && wr_en && i_paddr == pair_mode_pkg::ADDR_DEC_SEL) |=> (dec_sel == $past(i_pwdata[3:0]));
	endproperty
	a_dec_sel_write: assert property (p_dec_sel_write) else $error("decoder select write lost");

	property p_meta_dest_write;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && wr_en && i_paddr == pair_mode_pkg::ADDR_META_DEST) |=> (meta_dest == $past(i_pwdata[1:0]));
	endproperty
	a_meta_dest_write: assert property (p_meta_dest_write) else $error("metadata destination write lost");

	property p_status_ro;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_psel && !i_penable && i_pwrite && i_paddr == pair_mode_pkg::ADDR_DEC_STATUS) |=> o_pslverr;
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write not refused");

	property p_status_read;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_psel && !i_penable && !i_pwrite && i_paddr == pair_mode_pkg::ADDR_DEC_STATUS)
			|=> (o_prdata[2:0] == $past(fmt));
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read misses format");

	property p_fmt_unknown;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_dec_format > 3'h3) |=> (fmt == pair_mode_pkg::FMT_UNKNOWN);
	endproperty
	a_fmt_unknown: assert property (p_fmt_unknown) else $error("odd format code not unknown");

	property p_fmt_consumer;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_dec_format == 3'h2) |=> (fmt == pair_mode_pkg::FMT_CONSUMER);
	endproperty
	a_fmt_consumer: assert property (p_fmt_consumer) else $error("consumer format not reported");

	property p_chcnt_clamp;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_dec_format == 3'h2 && i_dec_chcnt > pair_mode_pkg::MAX_CH_CONSUMER)
			|=> (chcnt == pair_mode_pkg::MAX_CH_CONSUMER);
	endproperty
	a_chcnt_clamp: assert property (p_chcnt_clamp) else $error("consumer channel count not clamped");

	property p_meta_data;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && i_meta_valid) |=> (o_meta.data == $past(i_meta_byte));
	endproperty
	a_meta_data: assert property (p_meta_data) else $error("metadata byte altered");

endmodule : pair_mode_top

// >>> bench/audio_source_model.sv
// Far-side model: embedded and AES sources, decoder outputs and mixer returns
`timescale 1ns/10ps
module audio_source_model (
	// Clock
	input  wire logic                  i_mclk,
	// Sources toward the block
	output pair_mode_pkg::pair_s [7:0] o_sdi,
	output pair_mode_pkg::pair_s [5:0] o_aes,
	output pair_mode_pkg::pair_s [3:0] o_dec,
	output pair_mode_pkg::pair_s [7:0] o_mix
);
	logic [15:0] cnt = 16'h0000;

	// Plain always: the start value in the declaration is a second writer for always_ff
	always @(posedge i_mclk) begin
		cnt <= cnt + 16'h0001;
	end

	// Every word changes each cycle so a stale or swapped register is seen at once
	always_comb begin
		for (int p = 0; p < 8; p++) begin
			// Flag toggles so both handling branches are exercised
			o_sdi[p] = {1'b1, cnt[0] ^ p[0], 4'h1, p[3:0], cnt, ~{4'h1, p[3:0], cnt}};
			o_mix[p] = {1'b1, 1'b0, 4'h4, p[3:0], cnt, ~{4'h4, p[3:0], cnt}};
		end
		for (int a = 0; a < 6; a++) begin
			o_aes[a] = {1'b1, cnt[1], 4'h2, a[3:0], cnt, ~{4'h2, a[3:0], cnt}};
		end
		for (int d = 0; d < 4; d++) begin
			o_dec[d] = {1'b1, cnt[0], 4'h3, d[3:0], cnt, ~{4'h3, d[3:0], cnt}};
		end
	end
endmodule : audio_source_model

// >>> bench/test_audio_pair_mode_decoder_select.sv
// Self-checking bench for the pair mode and decoder select block
`timescale 1ns/10ps
module test_audio_pair_mode_decoder_select;
	logic                       mclk         = 1'b0;
	logic                       rst_n        = 1'b0;
	logic                       ce           = 1'b1;
	logic                       psel         = 1'b0;
	logic                       penable      = 1'b0;
	logic                       pwrite       = 1'b0;
	logic [11:0]                paddr        = 12'h000;
	logic [31:0]                pwdata       = 32'h0000_0000;
	logic [2:0]                 dec_format   = 3'h0;
	logic [3:0]                 dec_chcnt    = 4'h0;
	logic                       meta_valid   = 1'b0;
	logic [7:0]                 meta_byte    = 8'h00;
	logic                       dial_valid   = 1'b0;
	logic [4:0]                 dial_level   = 5'h00;
	logic [31:0]                prdata;
	logic                       pready;
	logic                       pslverr;
	logic [7:0]                 bypass;
	pair_mode_pkg::pair_s [7:0] sdi;
	pair_mode_pkg::pair_s [5:0] aes;
	pair_mode_pkg::pair_s [3:0] dec_out;
	pair_mode_pkg::pair_s [7:0] mix;
	pair_mode_pkg::pair_s [7:0] to_mix;
	pair_mode_pkg::pair_s [7:0] out;
	pair_mode_pkg::pair_s       dec_in;
	pair_mode_pkg::meta_s       meta;
	int                         err_count       = 0;
	int                         samples_checked = 0;

	always #2 mclk = ~mclk;

	audio_source_model src (.i_mclk(mclk), .o_sdi(sdi), .o_aes(aes), .o_dec(dec_out), .o_mix(mix));

	pair_mode_top #(.EXTENDED(1'b1)) dut (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_sdi(sdi), .i_aes(aes), .i_dec_out(dec_out), .i_dec_format(dec_format), .i_dec_chcnt(dec_chcnt),
		.i_meta_valid(meta_valid), .i_meta_byte(meta_byte), .i_dial_valid(dial_valid),
		.i_dial_level(dial_level), .o_dec_in(dec_in),
		.i_mix(mix), .o_to_mix(to_mix), .o_out(out), .o_bypass(bypass), .o_meta(meta)
	);

	task chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Pready is read before this edge's updates land, so it is the value sampled at the edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chk(64'(e), 64'(exp_err));
	endtask : wr

	task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(64'(r), 64'(exp));
		chk(64'(e), 64'(exp_err));
	endtask : rd_chk

	task t_regs;
		rd_chk(pair_mode_pkg::ADDR_PAIR_MODE, pair_mode_pkg::RST_PAIR_MODE, 1'b0);
		rd_chk(pair_mode_pkg::ADDR_PAIR_SRC, pair_mode_pkg::RST_PAIR_SRC, 1'b0);
		rd_chk(pair_mode_pkg::ADDR_DEC_SEL, 32'(pair_mode_pkg::RST_DEC_SEL), 1'b0);
		rd_chk(pair_mode_pkg::ADDR_META_DEST, 32'(pair_mode_pkg::RST_META_DEST), 1'b0);
		rd_chk(12'h014, 32'h0000_0000, 1'b1);
		wr(pair_mode_pkg::ADDR_DEC_STATUS, 32'hFFFF_FFFF, 1'b1);
		rd_chk(pair_mode_pkg::ADDR_DEC_STATUS, 32'h0000_0000, 1'b0);
	endtask : t_regs

	// Modes 0..3 and sources from embedded and decoder pairs, checked every cycle
	task t_paths;
		logic [31:0]          m;
		logic [31:0]          s;
		logic [7:0]           eb;
		pair_mode_pkg::pair_s eo [8];
		pair_mode_pkg::pair_s et [8];
		pair_mode_pkg::pair_s sv;
		logic [1:0]           md;
		m = 32'h0000_0000;
		s = 32'h0000_0000;
		for (int p = 0; p < 8; p++) begin
			m[2*p +: 2] = 2'(p % 4);
			s[4*p +: 4] = (p < 6) ? 4'(7 - p) : 4'(p + 3);
		end
		wr(pair_mode_pkg::ADDR_PAIR_MODE, m, 1'b0);
		wr(pair_mode_pkg::ADDR_PAIR_SRC, s, 1'b0);
		rd_chk(pair_mode_pkg::ADDR_PAIR_MODE, m, 1'b0);
		rd_chk(pair_mode_pkg::ADDR_PAIR_SRC, s, 1'b0);
		for (int k = 0; k < 9; k++) begin
			@(posedge mclk);
			#1;
			for (int p = 0; p < 8; p++) begin
				if (k > 0) begin
					chk(64'(out[p]), 64'(eo[p]));
					chk(64'(to_mix[p]), 64'(et[p]));
					chk(64'(bypass[p]), 64'(eb[p]));
				end
				sv = s[4*p+3] ? dec_out[s[4*p +: 2]] : sdi[s[4*p +: 3]];
				md = m[2*p +: 2];
				eb[p] = (md == 2'h1) || (md == 2'h3) || ((md == 2'h2) && sv.is_data);
				eo[p] = eb[p] ? sv : mix[p];
				et[p] = eb[p] ? '0 : sv;
			end
		end
	endtask : t_paths

	// Enable low must freeze the pair outputs and the decoder feed while the sources keep moving
	task t_freeze;
		pair_mode_pkg::pair_s [7:0] snap;
		pair_mode_pkg::pair_s       dsnap;
		@(posedge mclk);
		ce <= 1'b0;
		@(posedge mclk);
		#1;
		snap  = out;
		dsnap = dec_in;
		repeat (3) @(posedge mclk);
		#1;
		for (int p = 0; p < 8; p++) begin
			chk(64'(out[p]), 64'(snap[p]));
		end
		chk(64'(dec_in), 64'(dsnap));
		@(posedge mclk);
		ce <= 1'b1;
	endtask : t_freeze

	// Sixteen select codes: 0..13 are live on the extended variant, the rest give silence
	task t_dec_sel;
		pair_mode_pkg::pair_s e;
		for (int i = 0; i < 16; i++) begin
			wr(pair_mode_pkg::ADDR_DEC_SEL, 32'(i), 1'b0);
			rd_chk(pair_mode_pkg::ADDR_DEC_SEL, 32'(i), 1'b0);
			@(posedge mclk);
			#1;
			e = (i < 8) ? sdi[i] : ((i < 14) ? aes[i-8] : '0);
			@(posedge mclk);
			#1;
			chk(64'(dec_in), 64'(e));
		end
	endtask : t_dec_sel

	task t_status;
		logic [3:0] ch;
		logic [2:0] fm;
		for (int f = 0; f < 6; f++) begin
			@(posedge mclk);
			dec_format <= 3'(f);
			dec_chcnt  <= f[0] ? 4'h5 : 4'hF;
			dial_valid <= 1'b1;
			dial_level <= 5'(f + 3);
			@(posedge mclk);
			dial_valid <= 1'b0;
			dial_level <= 5'h1F;
			fm = (f > 4) ? 3'h4 : 3'(f);
			ch = (f == 2) ? 4'h6 : ((f == 3) ? 4'h5 : 4'h0);
			rd_chk(pair_mode_pkg::ADDR_DEC_STATUS, {12'h000, ch, 3'h0, 5'(f + 3), 5'h00, fm}, 1'b0);
		end
	endtask : t_status

	task t_meta;
		for (int d = 0; d < 4; d++) begin
			wr(pair_mode_pkg::ADDR_META_DEST, 32'(d), 1'b0);
			rd_chk(pair_mode_pkg::ADDR_META_DEST, 32'(d), 1'b0);
			@(posedge mclk);
			meta_valid <= 1'b1;
			meta_byte  <= 8'hA5 ^ 8'(d);
			@(posedge mclk);
			meta_valid <= 1'b0;
			#1;
			chk(64'(meta), 64'({1'b1, 2'(d), 8'hA5 ^ 8'(d)}));
			@(posedge mclk);
			#1;
			chk(64'(meta.valid), 64'h0);
		end
	endtask : t_meta

	task complete_run;
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		t_paths();
		t_freeze();
		t_dec_sel();
		t_status();
		t_meta();
		complete_run();
	end

	// The sequence needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		complete_run();
	end
endmodule : test_audio_pair_mode_decoder_select
